/* rtl/sspi_defs.svh */
// Purpose: Constants for the serial module SPI port: register map, fields, codes, counts.
// Assumes: 8-bit register port with a 2-bit address; one 10 MHz system clock.
// Notes: Included by its bare name; definitions only.
// Operation
// - Modes 000/001/010 are master with serial clock at system clock over 4/16/64.
// - Mode 011 is master on the sub clock; 100 master at timer match rate over two.
// - Mode 101 is slave on the external clock; 110 and 111 leave SPI inactive.
// - With module_enable low all SPI pins are released and the engine is held idle.
// - Raising module_enable leaves the format and data register contents untouched.
// - Slave select rising mid-frame sets the incomplete flag and the done flag together.
// - Software setting the incomplete flag never sets the done flag.
// - select_pin_enable high uses the select pin; low leaves that pin floating.
// - The shared data register is the only path for transmit and receive data.
// - The debounce select bits are stored but have no effect in SPI modes.
// - Bit 4 of the mode control register always reads zero.
// - Only the master starts transfers and drives the serial clock; full duplex.
// - Exactly one slave select line is provided for the master.
// - bit_order_select high shifts MSB first, low shifts LSB first.
// - clock_idle_level high idles the clock low; capture_edge_select picks capture edge.
// - Hardware sets the done flag when a frame completes; software clears it.
// - A data write during a transfer is ignored and sets the write collision flag.
`ifndef SSPI_DEFS_SVH
`define SSPI_DEFS_SVH

`define SSPI_ADDR_CTRL 2'h0
`define SSPI_ADDR_FMT 2'h1
`define SSPI_ADDR_DATA 2'h2

`define SSPI_CTRL_RST 8'hE0
`define SSPI_FMT_RST 8'h00
`define SSPI_DATA_RST 8'h00
`define SSPI_CTRL_WMASK 8'hEF

`define SSPI_CTRL_MODE_HI 7
`define SSPI_CTRL_MODE_LO 5
`define SSPI_CTRL_DEB_HI 3
`define SSPI_CTRL_DEB_LO 2
`define SSPI_CTRL_EN 1
`define SSPI_CTRL_ICF 0

`define SSPI_FMT_IDLE 5
`define SSPI_FMT_EDGE 4
`define SSPI_FMT_ORDER 3
`define SSPI_FMT_SELECT_PIN_ENABLE 2
`define SSPI_FMT_WRITE_COLLISION_FLAG 1
`define SSPI_FMT_TRF 0

`define SSPI_MODE_DIV4 3'h0
`define SSPI_MODE_DIV16 3'h1
`define SSPI_MODE_DIV64 3'h2
`define SSPI_MODE_SUB 3'h3
`define SSPI_MODE_TMR 3'h4
`define SSPI_MODE_SLAVE 3'h5

`define SSPI_HALF_DIV4 5'h01
`define SSPI_HALF_DIV16 5'h07
`define SSPI_HALF_DIV64 5'h1F

`define SSPI_LAST_BIT 4'h7
`define SSPI_END_EDGE 5'h10

`endif

/* rtl/sspi_pkg.sv */
// Purpose: Types shared by the SPI port modules.
// Assumes: Nothing beyond the defs header.
// Notes: Holds the engine state type only.
package sspi_pkg;
  typedef enum logic [1:0] {st_idle, st_master, st_slave} sspi_state_t;
endpackage : sspi_pkg

/* rtl/sspi_clk_if.sv */
// Purpose: Carries the master bit clock request and half-period ticks.
// Assumes: Both ends on the system clock.
// Notes: tick is a one-cycle enable pulse.
`timescale 1ns/1ps
`default_nettype none
interface sspi_clk_if;
  logic run;
  logic [2:0] sel;
  logic tick;
  modport gen (input run, input sel, output tick);
  modport core (output run, output sel, input tick);
endinterface : sspi_clk_if
`default_nettype wire

/* rtl/sspi_clkgen.sv */
// Purpose: Makes half-period tick pulses for the master serial clock.
// Assumes: timer_match is a one-cycle pulse on clk; sub_clk is asynchronous.
// Notes: Counter restarts whenever run drops, so in the divider modes the first tick is a full half period.
`timescale 1ns/1ps
`default_nettype none
module sspi_clkgen
  import sspi_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic sub_clk,
  input wire logic timer_match,
  sspi_clk_if.gen cif
);
`include "sspi_defs.svh"

  logic [4:0] cnt_ff;
  logic [4:0] nxt_cnt;
  logic sub_s1_ff;
  logic sub_s2_ff;
  logic sub_s3_ff;
  logic tick_c;

  function automatic logic [4:0] half_limit(input logic [2:0] sel);
    if (sel == `SSPI_MODE_DIV4) begin
      half_limit = `SSPI_HALF_DIV4;
    end else if (sel == `SSPI_MODE_DIV16) begin
      half_limit = `SSPI_HALF_DIV16;
    end else begin
      half_limit = `SSPI_HALF_DIV64;
    end
  endfunction : half_limit

  always_comb begin
    nxt_cnt = cnt_ff;
    tick_c = 1'b0;
    if (!cif.run) begin
      nxt_cnt = 5'h00;
    end else begin
      case (cif.sel)
        `SSPI_MODE_DIV4, `SSPI_MODE_DIV16, `SSPI_MODE_DIV64: begin
          if (cnt_ff == half_limit(cif.sel)) begin
            nxt_cnt = 5'h00;
            tick_c = 1'b1;
          end else begin
            nxt_cnt = cnt_ff + 5'h01;
          end
        end
        `SSPI_MODE_SUB: tick_c = sub_s2_ff ^ sub_s3_ff;
        `SSPI_MODE_TMR: tick_c = timer_match;
        default: tick_c = 1'b0;
      endcase
    end
  end

  assign cif.tick = tick_c;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_ff <= 5'h00;
      sub_s1_ff <= 1'b0;
      sub_s2_ff <= 1'b0;
      sub_s3_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      sub_s1_ff <= sub_clk;
      sub_s2_ff <= sub_s1_ff;
      sub_s3_ff <= sub_s2_ff;
    end
  end

endmodule : sspi_clkgen
`default_nettype wire

/* rtl/sspi_top.sv */
// Purpose: SPI personality of the serial module: registers, shift engine and pins.
// Assumes: Registers on a plain strobe port; pins sampled through two flip-flops.
// Notes: Output enables are active low; the I2C personality is not present.
//
// The implementer's own choices: the address map and strobed register access.
`timescale 1ns/1ps
`default_nettype none
module sspi_top
  import sspi_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic [1:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  input wire logic sub_clk,
  input wire logic timer_match,
  input wire logic sck_in,
  output logic sck_out,
  output logic sck_oe_n,
  input wire logic sdi_in,
  output logic sdo_out,
  output logic sdo_oe_n,
  input wire logic ss_n_in,
  output logic ss_n_out,
  output logic ss_n_oe_n,
  output logic transfer_done
);
`include "sspi_defs.svh"

  sspi_clk_if cif ();

  sspi_clkgen u_clkgen (
    .clk(clk),
    .nrst(nrst),
    .sub_clk(sub_clk),
    .timer_match(timer_match),
    .cif(cif)
  );

  logic [7:0] ctrl_ff;
  logic [7:0] fmt_ff;
  logic [7:0] sh_ff;
  logic [7:0] rdata_ff;
  sspi_state_t state_ff;
  logic [3:0] bitcnt_ff;
  logic [4:0] edgecnt_ff;
  logic [1:0] cap_d_ff;
  logic sck_ff;
  logic sdo_ff;
  logic ssn_ff;
  logic sck_oe_n_ff;
  logic sdo_oe_n_ff;
  logic ssn_oe_n_ff;

  logic [7:0] nxt_ctrl;
  logic [7:0] nxt_fmt;
  logic [7:0] nxt_sh;
  logic [7:0] nxt_rdata;
  sspi_state_t nxt_state;
  logic [3:0] nxt_bitcnt;
  logic [4:0] nxt_edgecnt;
  logic [1:0] nxt_cap;
  logic nxt_sck;
  logic nxt_sdo;
  logic nxt_ssn;
  logic nxt_sck_oe_n;
  logic nxt_sdo_oe_n;
  logic nxt_ssn_oe_n;

  logic sck_s1_ff;
  logic sck_s2_ff;
  logic sck_s3_ff;
  logic sdi_s1_ff;
  logic sdi_s2_ff;
  logic ssn_s1_ff;
  logic ssn_s2_ff;
  logic ssn_s3_ff;

  logic [2:0] mode;
  logic en;
  logic is_master;
  logic is_slave;
  logic idle_hi;
  logic cap_first;
  logic msb_first;
  logic select_pin_enable;
  logic slave_sel;
  logic ss_rise;
  logic sck_chg;
  logic set_trf;
  logic set_icf;
  logic set_write_collision_flag;
  logic leading;
  logic [7:0] sh_cur;

  // Next bit to put on the data line in the selected order.
  function automatic logic tx_bit(input logic [7:0] d, input logic msb);
    tx_bit = msb ? d[7] : d[0];
  endfunction : tx_bit

  // Shifts the sent bit out and the received bit in.
  function automatic logic [7:0] shift_in(input logic [7:0] d, input logic msb, input logic b);
    shift_in = msb ? {d[6:0], b} : {b, d[7:1]};
  endfunction : shift_in

  assign mode = ctrl_ff[`SSPI_CTRL_MODE_HI:`SSPI_CTRL_MODE_LO];
  assign en = ctrl_ff[`SSPI_CTRL_EN];
  // Debounce bits are not looked at anywhere in the SPI engine.
  assign is_master = en && (mode <= `SSPI_MODE_TMR);
  assign is_slave = en && (mode == `SSPI_MODE_SLAVE);
  assign idle_hi = ~fmt_ff[`SSPI_FMT_IDLE];
  assign cap_first = fmt_ff[`SSPI_FMT_EDGE];
  assign msb_first = fmt_ff[`SSPI_FMT_ORDER];
  assign select_pin_enable = fmt_ff[`SSPI_FMT_SELECT_PIN_ENABLE];
  assign slave_sel = !select_pin_enable || !ssn_s2_ff;
  assign ss_rise = select_pin_enable && ssn_s2_ff && !ssn_s3_ff;
  assign sck_chg = sck_s2_ff ^ sck_s3_ff;
  assign cif.run = (state_ff == st_master);
  assign cif.sel = mode;

  always_comb begin
    nxt_ctrl = ctrl_ff;
    nxt_fmt = fmt_ff;
    nxt_sh = sh_ff;
    nxt_rdata = 8'h00;
    nxt_state = state_ff;
    nxt_bitcnt = bitcnt_ff;
    nxt_edgecnt = edgecnt_ff;
    nxt_sck = sck_ff;
    nxt_sdo = sdo_ff;
    nxt_ssn = ssn_ff;
    set_trf = 1'b0;
    set_icf = 1'b0;
    set_write_collision_flag = 1'b0;
    leading = 1'b0;
    nxt_cap = {cap_d_ff[0], 1'b0};
    sh_cur = sh_ff;

    if (rd) begin
      if (addr == `SSPI_ADDR_CTRL) begin
        nxt_rdata = ctrl_ff & `SSPI_CTRL_WMASK;
      end else if (addr == `SSPI_ADDR_FMT) begin
        nxt_rdata = fmt_ff;
      end else if (addr == `SSPI_ADDR_DATA) begin
        nxt_rdata = sh_ff;
      end else begin
        nxt_rdata = 8'h00;
      end
    end

    case (state_ff)
      st_idle: begin
        nxt_sck = idle_hi;
        nxt_ssn = 1'b1;
        nxt_sdo = cap_first ? tx_bit(sh_ff, msb_first) : 1'b1;
        nxt_bitcnt = 4'h0;
        nxt_cap = 2'h0;
        if (is_slave) begin
          nxt_state = st_slave;
        end
      end
      st_master: begin
        // The synchronised data pin lags by two cycles, so a capture lands two cycles late.
        sh_cur = cap_d_ff[1] ? shift_in(sh_ff, msb_first, sdi_s2_ff) : sh_ff;
        nxt_sh = sh_cur;
        if (!is_master) begin
          nxt_state = st_idle;
          nxt_sck = idle_hi;
          nxt_ssn = 1'b1;
          nxt_cap = 2'h0;
        end else if (edgecnt_ff == `SSPI_END_EDGE) begin
          // Select rises only after the last clock edge and the last capture have landed.
          if (cap_d_ff == 2'h0) begin
            nxt_state = st_idle;
            nxt_ssn = 1'b1;
            set_trf = 1'b1;
          end
        end else if (cif.tick) begin
          leading = (sck_ff == idle_hi);
          nxt_sck = ~sck_ff;
          if (leading == cap_first) begin
            nxt_cap[0] = 1'b1;
          end else begin
            nxt_sdo = tx_bit(sh_cur, msb_first);
          end
          nxt_edgecnt = edgecnt_ff + 5'h01;
        end
      end
      st_slave: begin
        if (!is_slave) begin
          nxt_state = st_idle;
          nxt_bitcnt = 4'h0;
        end else if (ss_rise) begin
          if (bitcnt_ff != 4'h0) begin
            set_icf = 1'b1;
            set_trf = 1'b1;
          end
          nxt_bitcnt = 4'h0;
        end else if (slave_sel && sck_chg) begin
          leading = (sck_s3_ff == idle_hi);
          if (leading == cap_first) begin
            nxt_sh = shift_in(sh_ff, msb_first, sdi_s2_ff);
            if (bitcnt_ff == `SSPI_LAST_BIT) begin
              nxt_bitcnt = 4'h0;
              set_trf = 1'b1;
            end else begin
              nxt_bitcnt = bitcnt_ff + 4'h1;
            end
          end else begin
            nxt_sdo = tx_bit(sh_ff, msb_first);
          end
        end else if (bitcnt_ff == 4'h0) begin
          nxt_sdo = cap_first ? tx_bit(sh_ff, msb_first) : 1'b1;
        end
      end
      default: nxt_state = st_idle;
    endcase

    // Control writes never touch data or engine state, so enabling keeps settings.
    if (wr) begin
      if (addr == `SSPI_ADDR_CTRL) begin
        nxt_ctrl = wdata & `SSPI_CTRL_WMASK;
      end else if (addr == `SSPI_ADDR_FMT) begin
        nxt_fmt = wdata;
      end else if (addr == `SSPI_ADDR_DATA) begin
        if (state_ff == st_master || (state_ff == st_slave && bitcnt_ff != 4'h0)) begin
          set_write_collision_flag = 1'b1;
        end else begin
          nxt_sh = wdata;
          if (is_master && state_ff == st_idle) begin
            nxt_state = st_master;
            nxt_edgecnt = 5'h00;
            nxt_ssn = 1'b0;
            nxt_sdo = cap_first ? tx_bit(wdata, msb_first) : sdo_ff;
          end
        end
      end
    end

    // Hardware sets win over a software write in the same cycle.
    if (set_trf) begin
      nxt_fmt[`SSPI_FMT_TRF] = 1'b1;
    end
    if (set_write_collision_flag) begin
      nxt_fmt[`SSPI_FMT_WRITE_COLLISION_FLAG] = 1'b1;
    end
    if (set_icf) begin
      nxt_ctrl[`SSPI_CTRL_ICF] = 1'b1;
    end

    nxt_sck_oe_n = !is_master;
    nxt_ssn_oe_n = !(is_master && select_pin_enable);
    nxt_sdo_oe_n = !(is_master || (is_slave && slave_sel));
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_ff <= `SSPI_CTRL_RST;
      fmt_ff <= `SSPI_FMT_RST;
      sh_ff <= `SSPI_DATA_RST;
      rdata_ff <= 8'h00;
      state_ff <= st_idle;
      bitcnt_ff <= 4'h0;
      edgecnt_ff <= 5'h00;
      cap_d_ff <= 2'h0;
      sck_ff <= 1'b1;
      sdo_ff <= 1'b1;
      ssn_ff <= 1'b1;
      sck_oe_n_ff <= 1'b1;
      sdo_oe_n_ff <= 1'b1;
      ssn_oe_n_ff <= 1'b1;
    end else begin
      ctrl_ff <= nxt_ctrl;
      fmt_ff <= nxt_fmt;
      sh_ff <= nxt_sh;
      rdata_ff <= nxt_rdata;
      state_ff <= nxt_state;
      bitcnt_ff <= nxt_bitcnt;
      edgecnt_ff <= nxt_edgecnt;
      cap_d_ff <= nxt_cap;
      sck_ff <= nxt_sck;
      sdo_ff <= nxt_sdo;
      ssn_ff <= nxt_ssn;
      sck_oe_n_ff <= nxt_sck_oe_n;
      sdo_oe_n_ff <= nxt_sdo_oe_n;
      ssn_oe_n_ff <= nxt_ssn_oe_n;
    end
  end

  // Pin synchronisers; the first stage feeds only the second.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sck_s1_ff <= 1'b0;
      sck_s2_ff <= 1'b0;
      sck_s3_ff <= 1'b0;
      sdi_s1_ff <= 1'b0;
      sdi_s2_ff <= 1'b0;
      ssn_s1_ff <= 1'b1;
      ssn_s2_ff <= 1'b1;
      ssn_s3_ff <= 1'b1;
    end else begin
      sck_s1_ff <= sck_in;
      sck_s2_ff <= sck_s1_ff;
      sck_s3_ff <= sck_s2_ff;
      sdi_s1_ff <= sdi_in;
      sdi_s2_ff <= sdi_s1_ff;
      ssn_s1_ff <= ss_n_in;
      ssn_s2_ff <= ssn_s1_ff;
      ssn_s3_ff <= ssn_s2_ff;
    end
  end

  assign rdata = rdata_ff;
  assign sck_out = sck_ff;
  assign sck_oe_n = sck_oe_n_ff;
  assign sdo_out = sdo_ff;
  assign sdo_oe_n = sdo_oe_n_ff;
  assign ss_n_out = ssn_ff;
  assign ss_n_oe_n = ssn_oe_n_ff;
  assign transfer_done = fmt_ff[`SSPI_FMT_TRF];

endmodule : sspi_top
`default_nettype wire

/* tb/sspi_top_asserts.sv */
// Purpose: Pin-level assertions for the SPI port top module.
// Assumes: One clock domain; nrst asynchronous and active low.
// Notes: Counts serial clock edges inside each master frame.
`timescale 1ns/1ps
`default_nettype none
module sspi_asserts (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [1:0] addr,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata,
  input wire logic sck_out,
  input wire logic sck_oe_n,
  input wire logic sdo_oe_n,
  input wire logic ss_n_out,
  input wire logic ss_n_oe_n,
  input wire logic transfer_done
);
  logic sck_q_ff;
  logic ss_q_ff;
  logic [4:0] edges_ff;
  logic [4:0] nxt_edges;
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  always_comb begin
    nxt_edges = edges_ff + {4'h0, sck_out ^ sck_q_ff};
    if (ss_n_out && ss_q_ff) begin
      nxt_edges = 5'h00;
    end
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sck_q_ff <= 1'b1;
      ss_q_ff <= 1'b1;
      edges_ff <= 5'h00;
    end else begin
      sck_q_ff <= sck_out;
      ss_q_ff <= ss_n_out;
      edges_ff <= nxt_edges;
    end
  end
  chk_rdata_quiet: assert property (!$past(rd) |-> rdata == 8'h00)
    else $error("read data outside answer cycle");
  chk_trf_readback: assert property ($past(rd) && $past(addr) == 2'h1 |->
    rdata[0] == $past(transfer_done)) else $error("done flag readback wrong");
  chk_ss_pin_master: assert property (!ss_n_oe_n |-> !sck_oe_n)
    else $error("select pin driven outside master");
  chk_sdo_master: assert property (!sck_oe_n |-> !sdo_oe_n)
    else $error("master not driving data out");
  chk_ss_low_master: assert property (!ss_n_out |-> !sck_oe_n)
    else $error("select low outside master");
  chk_sck_in_frame: assert property (!sck_oe_n && !$past(sck_oe_n) &&
    sck_out != $past(sck_out) && !$past(wr) && !$past(wr, 2) |->
    !ss_n_out || !$past(ss_n_out)) else $error("clock moved outside frame");
  chk_sixteen_edges: assert property ($rose(ss_n_out) && !sck_oe_n |=>
    edges_ff == 5'h10) else $error("frame edge count wrong");
  chk_done_at_end: assert property ($rose(ss_n_out) && !sck_oe_n |->
    ##[0:1] transfer_done) else $error("done flag missing at frame end");
endmodule : sspi_asserts
bind sspi_top sspi_asserts i_sspi_asserts (.clk(clk), .nrst(nrst), .addr(addr), .wr(wr),
  .rd(rd), .rdata(rdata), .sck_out(sck_out), .sck_oe_n(sck_oe_n), .sdo_oe_n(sdo_oe_n),
  .ss_n_out(ss_n_out), .ss_n_oe_n(ss_n_oe_n), .transfer_done(transfer_done));
`default_nettype wire

/* tb/sspi_slave_model.sv */
// Purpose: Behavioural SPI slave peripheral facing the master port.
// Assumes: Format inputs settle before the select line falls.
// Notes: A released data line shows the inverse of its last bit.
`timescale 1ns/1ps
`default_nettype none
module sspi_slave_model (
  input wire logic sck,
  input wire logic ss_n,
  input wire logic mosi,
  input wire logic msb_first,
  input wire logic cap_rise,
  input wire logic cap_lead,
  input wire logic [7:0] tx,
  output logic miso,
  output logic [7:0] rx
);
  int idx = 0;
  function automatic logic pick(input int i);
    return msb_first ? tx[7 - (i % 8)] : tx[i % 8];
  endfunction : pick
  initial miso = 1'b0;
  initial rx = 8'h00;
  always @(negedge ss_n) begin
    miso = pick(0);
    idx = cap_lead ? 1 : 0;
  end
  always @(posedge ss_n) miso = ~miso;
  always @(sck) begin
    if (!ss_n && sck == cap_rise) begin
      rx = msb_first ? {rx[6:0], mosi} : {mosi, rx[7:1]};
    end else if (!ss_n) begin
      miso = pick(idx);
      idx++;
    end
  end
endmodule : sspi_slave_model
`default_nettype wire

/* tb/tb_serial_module_spi_port.sv */
// Purpose: Self-checking bench for the SPI port top module.
// Assumes: Slave model on the master pins; the bench plays the external master.
// Notes: Sub clock and timer match run free.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin n_errors++; \
  $display("Error t=%0t got %0h exp %0h", $time, (a), (b)); end end
module tb_serial_module_spi_port;
  logic clk = 1'b0, nrst = 1'b0, wr = 1'b0, rd = 1'b0, sub_clk = 1'b0, timer_match = 1'b0;
  logic [1:0] addr = 2'h0;
  logic [7:0] wdata = 8'h00, rdata, stx = 8'h00, srx;
  logic sck_out, sck_oe_n, sdo_out, sdo_oe_n, ss_n_out, ss_n_oe_n, transfer_done, miso;
  logic ext_sck = 1'b0, ext_ss = 1'b1, ext_sdi = 1'b0, ext_on = 1'b0;
  logic msb = 1'b0, crise = 1'b0, clead = 1'b0;
  wire logic sck_w = sck_oe_n ? ext_sck : sck_out;
  wire logic ss_w = ss_n_oe_n ? ext_ss : ss_n_out;
  wire logic sdi_w = ext_on ? ext_sdi : miso;
  int n_errors = 0, comparisons = 0, cyc = 0, tcnt = 0;
  int lo_t[5] = '{28, 124, 508, 70, 85};
  int hi_t[5] = '{40, 136, 520, 92, 106};
  sspi_top i_sspi_top (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .sub_clk(sub_clk), .timer_match(timer_match), .sck_in(sck_w),
    .sck_out(sck_out), .sck_oe_n(sck_oe_n), .sdi_in(sdi_w), .sdo_out(sdo_out),
    .sdo_oe_n(sdo_oe_n), .ss_n_in(ss_w), .ss_n_out(ss_n_out), .ss_n_oe_n(ss_n_oe_n),
    .transfer_done(transfer_done));
  sspi_slave_model i_sspi_slave_model (.sck(sck_w), .ss_n(ss_w), .mosi(sdo_out),
    .msb_first(msb), .cap_rise(crise), .cap_lead(clead), .tx(stx), .miso(miso), .rx(srx));
  always #50 clk = ~clk;
  always #500 sub_clk = ~sub_clk;
  always @(posedge clk) begin
    tcnt <= (tcnt == 5) ? 0 : tcnt + 1;
    timer_match <= (tcnt == 5);
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_errors++;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish();
    $display("comparisons=%0d errors=%0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : tally_and_finish
  task automatic wr_reg(input logic [1:0] a, input logic [7:0] v);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask : wr_reg
  task automatic expect_reg(input logic [1:0] a, input logic [7:0] e);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    `CHK(rdata, e)
    @(posedge clk);
  endtask : expect_reg
  task automatic master_frame(input logic [2:0] m, input int lo, input int hi);
    logic [7:0] fmt, txm;
    int n;
    fmt = {2'b00, m[0], m[1], m[2] ^ m[0], 3'b100};
    txm = 8'($urandom);
    stx = 8'($urandom);
    msb = fmt[3];
    crise = fmt[5] == fmt[4];
    clead = fmt[4];
    wr_reg(2'h0, {m, 1'b0, 2'($urandom), 2'b10});
    wr_reg(2'h1, fmt);
    wr_reg(2'h2, txm);
    wr_reg(2'h2, ~txm);
    n = 3;
    while (transfer_done !== 1'b1 && n < hi) begin
      @(posedge clk);
      n++;
    end
    `CHK(n >= lo && n < hi, 1'b1)
    `CHK(srx, txm)
    expect_reg(2'h2, stx);
    expect_reg(2'h1, fmt | 8'h03);
    wr_reg(2'h1, fmt);
    $display("done: master mode %0d", m);
  endtask : master_frame
  task automatic slave_frame(input int nb, input logic [7:0] ctrl_exp);
    logic [7:0] tx, dd, got;
    tx = 8'($urandom);
    dd = 8'($urandom);
    got = 8'h00;
    wr_reg(2'h0, 8'hA2);
    wr_reg(2'h1, 8'h3C);
    wr_reg(2'h2, dd);
    ext_on <= 1'b1;
    ext_ss <= 1'b0;
    repeat (4) @(posedge clk);
    for (int i = 0; i < nb; i++) begin
      ext_sdi <= tx[7 - i];
      repeat (6) @(posedge clk);
      got[7 - i] = sdo_out;
      ext_sck <= 1'b1;
      repeat (6) @(posedge clk);
      ext_sck <= 1'b0;
    end
    repeat (6) @(posedge clk);
    ext_ss <= 1'b1;
    repeat (6) @(posedge clk);
    expect_reg(2'h0, ctrl_exp);
    expect_reg(2'h1, 8'h3D);
    if (nb == 8) begin
      expect_reg(2'h2, tx);
      `CHK(got, dd)
    end
    wr_reg(2'h1, 8'h3C);
    $display("done: slave frame of %0d bits", nb);
  endtask : slave_frame
  initial begin
    void'($urandom(36063));
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    expect_reg(2'h0, 8'hE0);
    expect_reg(2'h1, 8'h00);
    expect_reg(2'h3, 8'h00);
    wr_reg(2'h3, 8'hFF);
    wr_reg(2'h0, 8'hFF);
    expect_reg(2'h0, 8'hEF);
    `CHK({sck_oe_n, sdo_oe_n, ss_n_oe_n}, 3'b111)
    $display("done: registers");
    for (int m = 0; m < 5; m++) begin
      master_frame(3'(m), lo_t[m], hi_t[m]);
    end
    wr_reg(2'h1, 8'hC0);
    wr_reg(2'h0, 8'h00);
    repeat (2) @(posedge clk);
    `CHK({sck_oe_n, sdo_oe_n, ss_n_oe_n}, 3'b111)
    wr_reg(2'h0, 8'h02);
    repeat (2) @(posedge clk);
    `CHK({sck_oe_n, ss_n_oe_n}, 2'b01)
    expect_reg(2'h1, 8'hC0);
    $display("done: enable and select pin");
    slave_frame(8, 8'hA2);
    slave_frame(3, 8'hA3);
    wr_reg(2'h0, 8'hA2);
    wr_reg(2'h0, 8'hA3);
    expect_reg(2'h1, 8'h3C);
    $display("done: software incomplete flag");
    tally_and_finish();
  end
endmodule : tb_serial_module_spi_port
`default_nettype wire
